// >>> dv/far_end_model.sv
// Loopback far-end model: takes lane words and sends them back
`timescale 1ns/100ps
`default_nettype none
module far_end_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Words from the codec
  input wire logic txValid,
  output logic txReady,
  input wire logic [31:0] txWord,
  input wire logic [3:0] txK,
  // Words back to the codec
  output logic rxValid,
  output logic [31:0] rxWord,
  output logic [3:0] rxK,
  // Test controls
  input wire logic slow,
  input wire logic corrupt
);
  logic got;
  logic [35:0] w;
  initial begin
    {txReady, rxValid, rxWord, rxK} = 38'h0;
  end
  // Echo one cycle later; idle lines invert so stale data never looks fresh
  always @(posedge sys_clk) begin
    got = resetn && txValid && txReady;
    w = {txK, txWord};
    #1;
    txReady = resetn && (slow ? $urandom % 8 == 0 : $urandom % 4 != 0);
    rxValid = got;
    if (got) begin
      {rxK, rxWord} = w;
      if (corrupt && w[7:0] == 8'h7c) rxWord[24] = ~w[24];
    end else begin
      {rxK, rxWord} = ~{rxK, rxWord};
    end
  end
endmodule
`default_nettype wire

// >>> dv/frame_codec_chk.sv
// Port-level assertion checker for the framing word codec
`timescale 1ns/100ps
`default_nettype none
module frame_codec_chk (
  // Clock and reset
  input wire sys_clk,
  input wire resetn,
  // Command side
  input wire cmdValid,
  input wire cmdReady,
  input wire [2:0] cmdKind,
  input wire [7:0] cmdChan,
  input wire [7:0] cmdBcByte,
  input wire cmdLate,
  // Sequence control
  input wire retryStart,
  input wire flush,
  input wire [7:0] seqNumber,
  // Lane side
  input wire txValid,
  input wire txReady,
  input wire [31:0] txWord,
  input wire [3:0] txK
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  // One-hot kind of the command taken at this edge
  wire [7:0] tkd = (cmdValid && cmdReady) ? (8'h01 << cmdKind) : 8'h00;
  wire adv = tkd[4] || tkd[5] || tkd[6];
  wire p = seqNumber[7];
  wire [6:0] c = seqNumber[6:0];
  a_dstart_word: assert property (tkd[1] |=>
    txK == 4'h1 && txWord == {8'h00, $past(cmdChan), 16'h50fc})
    else $error("bad data start");
  a_bstart_word: assert property (tkd[2] |=>
    txWord == {$past(cmdBcByte), $past(cmdChan), 16'h5dfc})
    else $error("bad bc start");
  a_istart_word: assert property (tkd[3] |=>
    txWord[23:0] == {$past(seqNumber), 16'h44fc})
    else $error("bad idle start");
  // Carried number is the advanced count, whatever flush or retry do next
  a_dend_word: assert property (tkd[4] |=>
    txWord[15:0] == {$past(p), $past(c) + 7'h1, 8'h1c})
    else $error("bad data end");
  a_bend_word: assert property (tkd[5] |=>
    txWord[23:0] == {$past(p), $past(c) + 7'h1, 7'h00, $past(cmdLate),
      8'h5c}) else $error("bad bc end");
  a_token_word: assert property (tkd[6] |=>
    txWord[23:0] == {$past(p), $past(c) + 7'h1, $past(cmdChan), 8'h7c})
    else $error("bad token");
  a_seq_step: assert property (adv && !flush && !retryStart |=>
    seqNumber == {$past(p), $past(c) + 7'h1}) else $error("bad seq step");
  a_seq_flush: assert property (flush |=> seqNumber == 8'h00)
    else $error("flush did not clear");
  a_pol_flip: assert property (retryStart && !flush && !adv |=>
    seqNumber == {~$past(p), $past(c)}) else $error("bad polarity");
  a_word_held: assert property (txValid && !txReady |=>
    txValid && $stable(txWord) && $stable(txK)) else $error("word lost");
endmodule
bind frame_codec frame_codec_chk chk (.sys_clk(sys_clk), .resetn(resetn),
  .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdKind(cmdKind),
  .cmdChan(cmdChan), .cmdBcByte(cmdBcByte), .cmdLate(cmdLate),
  .retryStart(retryStart), .flush(flush), .seqNumber(seqNumber),
  .txValid(txValid), .txReady(txReady), .txWord(txWord), .txK(txK));
`default_nettype wire

// >>> dv/tb.sv
// Self-checking bench for the framing word codec with a loopback far end
`timescale 1ns/100ps
`default_nettype none
`include "frame_codec_defs.vh"
module tb;
  logic sys_clk, resetn, cmdValid, cmdLate, retryStart, flush, slow, corrupt;
  logic inFrame;
  logic [2:0] cmdKind;
  logic [31:0] cmdData;
  logic [3:0] cmdK;
  logic [7:0] cmdChan, cmdBcByte, seq;
  logic [15:0] c8, c16;
  wire cmdReady, txValid, txReady, rxValid, rxEvtValid, rxLate, rxIdleFrame;
  wire [7:0] seqNumber, rxField1, rxField2;
  wire [31:0] txWord, rxWord, rxDataOut;
  wire [3:0] txK, rxK, rxKOut;
  wire [2:0] rxEvtKind;
  int num_errors, n_tests, t;
  logic [35:0] expTx[$];
  logic [51:0] expEv[$];
  logic [51:0] e;
  frame_codec dut (.sys_clk(sys_clk), .resetn(resetn), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmdKind(cmdKind), .cmdData(cmdData), .cmdK(cmdK),
    .cmdChan(cmdChan), .cmdBcByte(cmdBcByte), .cmdLate(cmdLate),
    .retryStart(retryStart), .flush(flush), .seqNumber(seqNumber),
    .txValid(txValid), .txReady(txReady), .txWord(txWord), .txK(txK),
    .rxValid(rxValid), .rxWord(rxWord), .rxK(rxK), .rxEvtValid(rxEvtValid),
    .rxEvtKind(rxEvtKind), .rxField1(rxField1), .rxField2(rxField2),
    .rxLate(rxLate), .rxDataOut(rxDataOut), .rxKOut(rxKOut),
    .rxIdleFrame(rxIdleFrame));
  far_end_model far (.sys_clk(sys_clk), .resetn(resetn), .txValid(txValid),
    .txReady(txReady), .txWord(txWord), .txK(txK), .rxValid(rxValid),
    .rxWord(rxWord), .rxK(rxK), .slow(slow), .corrupt(corrupt));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("errors %0d comparisons %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic hang();
    num_errors++;
    $display("unexpected at %0t: wait ran out", $time);
    stop_test();
  endtask
  // MSB-first byte-serial CRC, byte 0 first, no reflection
  function automatic [15:0] crc(input [15:0] c, input [31:0] w, input int n,
      input bit wide);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < n; i++) begin
      r = r ^ (wide ? {w[8*i+:8], 8'h00} : {8'h00, w[8*i+:8]});
      for (int b = 0; b < 8; b++) begin
        r = {r[14:0], 1'b0} ^ ((wide ? r[15] : r[7]) ?
          (wide ? `FC_CRC16_POLY : `FC_CRC8_POLY) : 16'h0000);
        if (!wide) r[15:8] = 8'h00;
      end
    end
    crc = r;
  endfunction
  // Offer one command, queue the expected word and receive event
  task automatic send(input logic [2:0] k, input logic [7:0] ch,
      input logic [31:0] d);
    logic [31:0] w;
    logic [15:0] r;
    logic bad;
    if (k >= 3'h4) seq = {seq[7], seq[6:0] + 7'h1};
    case (k)
      3'h0: w = d;
      3'h1: w = {8'h00, ch, 16'h50fc};
      3'h2: w = {d[7:0], ch, 16'h5dfc};
      3'h3: w = {8'h00, seq, 16'h44fc};
      3'h4: w = {16'h0000, seq, 8'h1c};
      3'h5: w = {8'h00, seq, 7'h00, d[0], 8'h5c};
      default: w = {8'h00, seq, ch, 8'h7c};
    endcase
    r = crc(`FC_CRC8_INIT, w, 3, 0);
    if (k == 3'h3 || k == 3'h6) w[31:24] = r[7:0];
    if (k == 3'h1) c16 = `FC_CRC16_INIT;
    if (k == 3'h2) c8 = `FC_CRC8_INIT;
    c16 = crc(c16, w, k == 3'h4 ? 2 : 4, 1);
    c8 = crc(c8, w, k == 3'h5 ? 3 : 4, 0);
    if (k == 3'h4) w[31:16] = c16;
    if (k == 3'h5) w[31:24] = c8[7:0];
    // Bad: corrupted token, or a control word with an unknown first symbol
    bad = (corrupt && k == 3'h6) || (k == 3'h0 && cmdK[0]);
    expTx.push_back({(k != 3'h0) ? 4'h1 : cmdK, w});
    // Data words outside a data or broadcast frame give no event
    if (k != 3'h0 || bad || inFrame)
      expEv.push_back({bad ? 3'h7 : k, bad ? {5'h00, k == 3'h0 ? 3'h7 : k} :
        (k == 1 || k == 2 || k == 6) ? ch : seq, k == 2 ? d[7:0] : k == 6 ?
        seq : 8'h00, d[0], w});
    if (k inside {1, 2, 3, 4, 5}) inFrame = (k == 1 || k == 2);
    {cmdKind, cmdChan, cmdData, cmdBcByte, cmdLate} = {k, ch, d, d[7:0], d[0]};
    cmdValid = 1'b1;
    for (t = 0; t < 200; t++) begin
      @(posedge sys_clk);
      if (cmdReady === 1'b1) break;
    end
    #1;
    if (t == 200) hang();
  endtask
  // One frame: 0 data, 1 broadcast, 2 idle start, 3 flow token
  task automatic frame(input logic [2:0] ty);
    logic [7:0] ch;
    ch = 8'($urandom);
    if (ty < 3'h2) begin
      send(ty + 3'h1, ch, $urandom);
      for (int i = 0; i < ch[1:0]; i++) send(3'h0, 8'h00, $urandom);
      send(ty + 3'h4, 8'h00, $urandom);
    end else begin
      send(ty == 3'h2 ? 3'h3 : 3'h6, ch, 32'h0);
    end
  endtask
  task automatic drain(input string nm);
    cmdValid = 1'b0;
    for (t = 0; t < 400 && expTx.size() + expEv.size() > 0; t++)
      @(posedge sys_clk);
    #1;
    if (t == 400) hang();
    $display("test %s done", nm);
  endtask
  task automatic pulse(input logic r, input logic f);
    {retryStart, flush} = {r, f};
    @(posedge sys_clk);
    #1;
    {retryStart, flush} = 2'b00;
    seq = f ? 8'h00 : {~seq[7], seq[6:0]};
    chk(seqNumber, seq);
  endtask
  // Transmit words against the model
  always @(posedge sys_clk) begin
    if (resetn && txValid && txReady) chk({txK, txWord}, expTx.pop_front());
  end
  // Receive events against the model
  always @(posedge sys_clk) begin
    if (resetn && rxEvtValid) begin
      e = expEv.pop_front();
      chk(rxEvtKind, e[51:49]);
      chk(rxKOut, {3'h0, e[51:49] != 3'h0});
      if (e[51:49] == 3'h0) chk(rxDataOut, e[31:0]);
      else if (e[51:49] == 3'h7) chk(rxField1, e[48:41]);
      else chk({rxField1, rxField2}, e[48:33]);
      if (e[51:49] == 3'h5) chk(rxLate, e[32]);
      if (e[51:49] inside {1, 2, 3}) chk(rxIdleFrame, e[51:49] == 3);
    end
  end
  // Main sequence
  initial begin
    {resetn, cmdValid, cmdLate, retryStart, flush, slow, corrupt, inFrame} = 8'h00;
    {cmdKind, cmdData, cmdK, cmdChan, cmdBcByte, seq, c8, c16} = '0;
    void'($urandom(12));
    repeat (12) @(posedge sys_clk);
    #1;
    resetn = 1'b1;
    chk({cmdReady, txValid, seqNumber}, 36'h200);
    $display("test reset done");
    for (int i = 0; i < 40; i++) begin
      slow = i[3];
      frame(3'($urandom % 4));
    end
    drain("random frames");
    repeat (130) send(3'h6, 8'($urandom), 32'h0);
    drain("token wrap");
    chk(seqNumber, seq);
    pulse(1'b1, 1'b0);
    frame(3'h2);
    frame(3'h3);
    drain("retry");
    pulse(1'b1, 1'b1);
    frame(3'h1);
    drain("flush");
    // Unknown control word gives an error event; loose data word is dropped
    cmdK = 4'h1;
    send(3'h0, 8'h00, 32'h000000bc);
    cmdK = 4'h0;
    send(3'h0, 8'h00, $urandom);
    drain("stray words");
    corrupt = 1'b1;
    repeat (3) send(3'h6, 8'($urandom), 32'h0);
    drain("bad crc");
    corrupt = 1'b0;
    resetn = 1'b0;
    seq = 8'h00;
    repeat (2) @(posedge sys_clk);
    #1;
    resetn = 1'b1;
    chk(seqNumber, 8'h00);
    frame(3'h3);
    drain("second reset");
    stop_test();
  end
endmodule
`default_nettype wire

// >>> rtl/crc_bytes.v
// Parameterised byte-serial CRC over the low NB bytes of a word
`timescale 1ns/100ps
`default_nettype none
module crc_bytes #(
  parameter W = 8,
  parameter [15:0] POLY = 16'h0007,
  parameter NB = 4
) (
  // Running value in and out
  input wire [W-1:0] crcIn,
  input wire [31:0] data,
  output reg [W-1:0] crcOut
);
  // Symbol 0 first, each byte MSB first; polynomial set by parameter
  always @* begin : calc
    integer b;
    integer i;
    reg fb;
    b = 0;
    i = 0;
    fb = 1'b0;
    crcOut = crcIn;
    for (b = 0; b < NB; b = b + 1) begin
      for (i = 7; i >= 0; i = i - 1) begin
        fb = crcOut[W-1] ^ data[b*8+i];
        crcOut = {crcOut[W-2:0], 1'b0};
        if (fb) begin
          crcOut = crcOut ^ POLY[W-1:0];
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> rtl/frame_codec.v
// Framing and flow token word builder and parser for one link end
`timescale 1ns/100ps
`default_nettype none
`include "frame_codec_defs.vh"
module frame_codec (
  // Clock and reset
  input wire sys_clk,
  input wire resetn,
  // User command port
  input wire cmdValid,
  output wire cmdReady,
  input wire [2:0] cmdKind,
  input wire [31:0] cmdData,
  input wire [3:0] cmdK,
  input wire [7:0] cmdChan,
  input wire [7:0] cmdBcByte,
  input wire cmdLate,
  // Sequence control
  input wire retryStart,
  input wire flush,
  output wire [7:0] seqNumber,
  // Transmit words toward the lane
  output wire txValid,
  input wire txReady,
  output wire [31:0] txWord,
  output wire [3:0] txK,
  // Receive words from the lane
  input wire rxValid,
  input wire [31:0] rxWord,
  input wire [3:0] rxK,
  // Receive events
  output wire rxEvtValid,
  output wire [2:0] rxEvtKind,
  output wire [7:0] rxField1,
  output wire [7:0] rxField2,
  output wire rxLate,
  output wire [31:0] rxDataOut,
  output wire [3:0] rxKOut,
  output wire rxIdleFrame
);
  localparam [1:0] ST_NONE = 2'd0;
  localparam [1:0] ST_IDLE = 2'd1;
  localparam [1:0] ST_DATA = 2'd2;
  localparam [1:0] ST_BCAST = 2'd3;

  reg txValid_reg;
  reg [31:0] txWord_reg;
  reg [3:0] txK_reg;
  reg [6:0] seqCnt_reg;
  reg seqPol_reg;
  reg [15:0] txCrc16_reg;
  reg [7:0] txCrc8_reg;
  reg [31:0] asmWord;
  reg [3:0] asmK;
  reg [15:0] txCrc16_next;
  reg [7:0] txCrc8_next;
  reg bumpSeq;
  wire take;
  wire [7:0] seqNew;
  wire [15:0] t16Full;
  wire [15:0] t16Half;
  wire [7:0] t8Full;
  wire [7:0] t8Three;

  // Output stage holds one word; a stalled lane stalls the user
  assign take = cmdValid && cmdReady;
  assign cmdReady = !txValid_reg || txReady;
  assign txValid = txValid_reg;
  assign txWord = txWord_reg;
  assign txK = txK_reg;
  assign seqNumber = {seqPol_reg, seqCnt_reg};
  // Number carried by a new frame end or token: the advanced count
  assign seqNew = {seqPol_reg, seqCnt_reg + 7'd1};

  // Data and broadcast start words restart their running CRC, data words continue it
  crc_bytes #(.W(16), .POLY(`FC_CRC16_POLY), .NB(4)) txC16Full (
    .crcIn(cmdKind == `FC_KIND_DSTART ? `FC_CRC16_INIT : txCrc16_reg),
    .data(asmWord),
    .crcOut(t16Full)
  );
  // End of data frame covers its first two symbols only
  crc_bytes #(.W(16), .POLY(`FC_CRC16_POLY), .NB(2)) txC16Half (
    .crcIn(txCrc16_reg),
    .data(asmWord),
    .crcOut(t16Half)
  );
  crc_bytes #(.W(8), .POLY(`FC_CRC8_POLY), .NB(4)) txC8Full (
    .crcIn(cmdKind == `FC_KIND_BSTART ? `FC_CRC8_INIT : txCrc8_reg),
    .data(asmWord),
    .crcOut(t8Full)
  );
  // Three-symbol CRC: whole idle start or token, or broadcast frame tail
  crc_bytes #(.W(8), .POLY(`FC_CRC8_POLY), .NB(3)) txC8Three (
    .crcIn(cmdKind == `FC_KIND_BEND ? txCrc8_reg : `FC_CRC8_INIT),
    .data(asmWord),
    .crcOut(t8Three)
  );

  // Build the word without its CRC symbols, symbol 0 in the low byte
  always @* begin
    asmWord = cmdData;
    asmK = cmdK;
    bumpSeq = 1'b0;
    case (cmdKind)
      `FC_KIND_DSTART: begin
        asmWord = {`FC_D0_0, cmdChan,
          `FC_D16_2, `FC_K28_7};
        asmK = 4'h1;
      end
      `FC_KIND_BSTART: begin
        asmWord = {cmdBcByte, cmdChan,
          `FC_D29_2, `FC_K28_7};
        asmK = 4'h1;
      end
      `FC_KIND_ISTART: begin
        asmWord = {8'h00, seqNumber, `FC_D4_2, `FC_K28_7};
        asmK = 4'h1;
      end
      `FC_KIND_DEND: begin
        asmWord = {16'h0000, seqNew, `FC_K28_0};
        asmK = 4'h1;
        bumpSeq = 1'b1;
      end
      `FC_KIND_BEND: begin
        asmWord = {8'h00, seqNew, 7'h00,
          cmdLate, `FC_K28_2};
        asmK = 4'h1;
        bumpSeq = 1'b1;
      end
      `FC_KIND_TOKEN: begin
        asmWord = {8'h00, seqNew, cmdChan, `FC_K28_3};
        asmK = 4'h1;
        bumpSeq = 1'b1;
      end
      default: begin
        asmWord = cmdData;
        asmK = cmdK;
      end
    endcase
  end

  // Next running CRC values for frame bodies
  always @* begin
    txCrc16_next = txCrc16_reg;
    txCrc8_next = txCrc8_reg;
    if (cmdKind == `FC_KIND_DSTART || cmdKind == `FC_KIND_DATA) begin
      txCrc16_next = t16Full;
    end
    if (cmdKind == `FC_KIND_BSTART || cmdKind == `FC_KIND_DATA) begin
      txCrc8_next = t8Full;
    end
  end

  // Transmit register and sequence counter
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      txValid_reg <= 1'b0;
      txWord_reg <= 32'h00000000;
      txK_reg <= 4'h0;
      seqCnt_reg <= `FC_SEQ_RESET;
      seqPol_reg <= 1'b0;
      txCrc16_reg <= `FC_CRC16_INIT;
      txCrc8_reg <= `FC_CRC8_INIT;
    end else begin
      if (take) begin
        txValid_reg <= 1'b1;
        txK_reg <= asmK;
        txCrc16_reg <= txCrc16_next;
        txCrc8_reg <= txCrc8_next;
        case (cmdKind)
          `FC_KIND_ISTART, `FC_KIND_TOKEN: begin
            txWord_reg <= {t8Three, asmWord[23:0]};
          end
          `FC_KIND_DEND: begin
            txWord_reg <= {t16Half[15:8], t16Half[7:0], asmWord[15:0]};
          end
          `FC_KIND_BEND: begin
            txWord_reg <= {t8Three, asmWord[23:0]};
          end
          default: begin
            txWord_reg <= asmWord;
          end
        endcase
      end else if (txReady) begin
        txValid_reg <= 1'b0;
      end
      // Flush wins over a word sent in the same cycle
      if (flush) begin
        seqCnt_reg <= `FC_SEQ_RESET;
        seqPol_reg <= 1'b0;
      end else begin
        if (take && bumpSeq) begin
          seqCnt_reg <= seqNew[6:0];
        end
        if (retryStart) begin
          seqPol_reg <= !seqPol_reg;
        end
      end
    end
  end

  // Receive side
  reg [1:0] rxState_reg;
  reg [1:0] rxState_next;
  reg [15:0] rxCrc16_reg;
  reg [7:0] rxCrc8_reg;
  reg rxEvtValid_reg;
  reg [2:0] rxEvtKind_reg;
  reg [7:0] rxField1_reg;
  reg [7:0] rxField2_reg;
  reg rxLate_reg;
  reg [31:0] rxDataOut_reg;
  reg [3:0] rxKOut_reg;
  reg [2:0] rxKind;
  wire [15:0] r16Full;
  wire [15:0] r16Half;
  wire [7:0] r8Full;
  wire [7:0] r8Three;
  wire crcBad;

  assign rxEvtValid = rxEvtValid_reg;
  assign rxEvtKind = rxEvtKind_reg;
  assign rxField1 = rxField1_reg;
  assign rxField2 = rxField2_reg;
  assign rxLate = rxLate_reg;
  assign rxDataOut = rxDataOut_reg;
  assign rxKOut = rxKOut_reg;
  assign rxIdleFrame = (rxState_reg == ST_IDLE);

  crc_bytes #(.W(16), .POLY(`FC_CRC16_POLY), .NB(4)) rxC16Full (
    .crcIn(rxKind == `FC_KIND_DSTART ? `FC_CRC16_INIT : rxCrc16_reg),
    .data(rxWord),
    .crcOut(r16Full)
  );
  crc_bytes #(.W(16), .POLY(`FC_CRC16_POLY), .NB(2)) rxC16Half (
    .crcIn(rxCrc16_reg),
    .data(rxWord),
    .crcOut(r16Half)
  );
  crc_bytes #(.W(8), .POLY(`FC_CRC8_POLY), .NB(4)) rxC8Full (
    .crcIn(rxKind == `FC_KIND_BSTART ? `FC_CRC8_INIT : rxCrc8_reg),
    .data(rxWord),
    .crcOut(r8Full)
  );
  crc_bytes #(.W(8), .POLY(`FC_CRC8_POLY), .NB(3)) rxC8Three (
    .crcIn(rxKind == `FC_KIND_BEND ? rxCrc8_reg : `FC_CRC8_INIT),
    .data(rxWord),
    .crcOut(r8Three)
  );

  // Classify by first symbol, start words also by second; unknown control words fall to error kind
  always @* begin
    rxKind = `FC_KIND_ERR;
    if (!rxK[0]) begin
      rxKind = `FC_KIND_DATA;
    end else if (rxWord[7:0] == `FC_K28_7) begin
      if (rxWord[15:8] == `FC_D16_2) begin
        rxKind = `FC_KIND_DSTART;
      end else if (rxWord[15:8] == `FC_D29_2) begin
        rxKind = `FC_KIND_BSTART;
      end else if (rxWord[15:8] == `FC_D4_2) begin
        rxKind = `FC_KIND_ISTART;
      end
    end else if (rxWord[7:0] == `FC_K28_0) begin
      rxKind = `FC_KIND_DEND;
    end else if (rxWord[7:0] == `FC_K28_2) begin
      rxKind = `FC_KIND_BEND;
    end else if (rxWord[7:0] == `FC_K28_3) begin
      rxKind = `FC_KIND_TOKEN;
    end
  end

  // CRC check of the words that carry one
  assign crcBad =
    ((rxKind == `FC_KIND_ISTART || rxKind == `FC_KIND_TOKEN ||
      rxKind == `FC_KIND_BEND) && r8Three != rxWord[31:24]) ||
    (rxKind == `FC_KIND_DEND && r16Half != rxWord[31:16]);

  // Frame state: idle frames have no end word, next start closes them
  always @* begin
    rxState_next = rxState_reg;
    if (rxValid && !crcBad) begin
      case (rxKind)
        `FC_KIND_DSTART: rxState_next = ST_DATA;
        `FC_KIND_BSTART: rxState_next = ST_BCAST;
        `FC_KIND_ISTART: rxState_next = ST_IDLE;
        `FC_KIND_DEND, `FC_KIND_BEND: rxState_next = ST_NONE;
        default: rxState_next = rxState_reg;
      endcase
    end
  end

  // Receive event register; data words pass only inside a data or broadcast frame
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rxState_reg <= ST_NONE;
      rxCrc16_reg <= `FC_CRC16_INIT;
      rxCrc8_reg <= `FC_CRC8_INIT;
      rxEvtValid_reg <= 1'b0;
      rxEvtKind_reg <= `FC_KIND_DATA;
      rxField1_reg <= 8'h00;
      rxField2_reg <= 8'h00;
      rxLate_reg <= 1'b0;
      rxDataOut_reg <= 32'h00000000;
      rxKOut_reg <= 4'h0;
    end else begin
      rxEvtValid_reg <= 1'b0;
      rxState_reg <= rxState_next;
      if (rxValid) begin
        rxDataOut_reg <= rxWord;
        rxKOut_reg <= rxK;
        rxEvtKind_reg <= rxKind;
        rxLate_reg <= 1'b0;
        if (rxKind == `FC_KIND_DSTART || rxKind == `FC_KIND_DATA) begin
          rxCrc16_reg <= r16Full;
        end
        if (rxKind == `FC_KIND_BSTART || rxKind == `FC_KIND_DATA) begin
          rxCrc8_reg <= r8Full;
        end
        if (crcBad || rxKind == `FC_KIND_ERR) begin
          // Bad word is dropped; field 1 names what was lost
          rxEvtValid_reg <= 1'b1;
          rxEvtKind_reg <= `FC_KIND_ERR;
          rxField1_reg <= {5'h00, rxKind};
          rxField2_reg <= 8'h00;
        end else begin
          case (rxKind)
            `FC_KIND_DATA: begin
              rxEvtValid_reg <= (rxState_reg == ST_DATA) ||
                                (rxState_reg == ST_BCAST);
              rxField1_reg <= 8'h00;
              rxField2_reg <= 8'h00;
            end
            `FC_KIND_DSTART, `FC_KIND_BSTART: begin
              rxEvtValid_reg <= 1'b1;
              rxField1_reg <= rxWord[23:16];
              rxField2_reg <= rxWord[31:24];
            end
            `FC_KIND_ISTART: begin
              rxEvtValid_reg <= 1'b1;
              rxField1_reg <= rxWord[23:16];
              rxField2_reg <= 8'h00;
            end
            `FC_KIND_DEND: begin
              rxEvtValid_reg <= 1'b1;
              rxField1_reg <= rxWord[15:8];
              rxField2_reg <= 8'h00;
            end
            `FC_KIND_BEND: begin
              // Upper bits of the late symbol are not looked at
              rxEvtValid_reg <= 1'b1;
              rxLate_reg <= rxWord[8+`FC_LATE_POS];
              rxField1_reg <= rxWord[23:16];
              rxField2_reg <= 8'h00;
            end
            default: begin
              rxEvtValid_reg <= 1'b1;
              rxField1_reg <= rxWord[15:8];
              rxField2_reg <= rxWord[23:16];
            end
          endcase
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> rtl/frame_codec_defs.vh
// Symbol codes, command codes and CRC settings of the framing word codec
// How it works
// - Data-frame start word: comma K28.7 first, then D16.2.
// - Third symbol of data-frame start is the virtual channel number.
// - Fourth symbol of data-frame start is reserved and sent as D0.0.
// - Broadcast-frame start word: comma K28.7 first, then D29.2.
// - Third symbol of broadcast start is the broadcast channel number.
// - Fourth symbol of broadcast start holds channel sequence and type.
// - Idle-frame start word: comma K28.7 first, then D4.2.
// - Idle start fourth symbol is an 8-bit CRC over the word.
// - Idle frame ends when a data, broadcast or idle start arrives.
// - Data-frame end word starts with non-comma K28.0, sent first.
// - Second symbol of data-frame end is that frame's sequence number.
// - Data-frame end carries low then high byte of frame CRC-16.
// - Broadcast-frame end word starts with non-comma K28.2, sent first.
// - Bit 0 of broadcast end second symbol is the late flag.
// - Bits 1 to 7 of that symbol sent zero, ignored on receive.
// - Third symbol of broadcast end is that frame's sequence number.
// - Broadcast end fourth symbol is CRC-8 over the whole frame.
// - Flow token sent whenever a channel buffer can take a frame; the codec sends one only on a token command.
// - Flow token starts with K28.3, second symbol is the channel.
// - Flow token ends with CRC-8, checked before the token is used.
`ifndef FRAME_CODEC_DEFS_VH
`define FRAME_CODEC_DEFS_VH
// Symbol values
`define FC_K28_7 8'hfc
`define FC_K28_0 8'h1c
`define FC_K28_2 8'h5c
`define FC_K28_3 8'h7c
`define FC_D16_2 8'h50
`define FC_D29_2 8'h5d
`define FC_D4_2 8'h44
`define FC_D0_0 8'h00
// Command and event kinds
`define FC_KIND_DATA 3'h0
`define FC_KIND_DSTART 3'h1
`define FC_KIND_BSTART 3'h2
`define FC_KIND_ISTART 3'h3
`define FC_KIND_DEND 3'h4
`define FC_KIND_BEND 3'h5
`define FC_KIND_TOKEN 3'h6
`define FC_KIND_ERR 3'h7
// CRC settings, plain defaults
`define FC_CRC8_POLY 16'h0007
`define FC_CRC8_INIT 8'h00
`define FC_CRC16_POLY 16'h1021
`define FC_CRC16_INIT 16'hffff
// Reset value and late flag bit position
// Sequence count reset value, polarity bit clears separately
`define FC_SEQ_RESET 7'h00
`define FC_LATE_POS 0
`endif
